// File: nand_host_pkg.sv
package nand_host_pkg;

  // --------------------------------------------------------------
  // command codes
  // --------------------------------------------------------------
  localparam logic [7:0] CMD_READ_1 = 8'h00;
  localparam logic [7:0] CMD_READ_2 = 8'h30;
  localparam logic [7:0] CMD_PROG_1 = 8'h80;
  localparam logic [7:0] CMD_PROG_2 = 8'h10;
  localparam logic [7:0] CMD_ERASE_1 = 8'h60;
  localparam logic [7:0] CMD_ERASE_2 = 8'hd0;
  localparam logic [7:0] CMD_COLOUT_1 = 8'h05;
  localparam logic [7:0] CMD_COLOUT_2 = 8'he0;
  localparam logic [7:0] CMD_COLIN = 8'h85;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'hff;

  // --------------------------------------------------------------
  // geometry
  // --------------------------------------------------------------
  localparam int COL_W = 12;
  localparam int PAGE_W = 15;
  localparam logic [11:0] COL_LAST = 12'h83f;  // 2111, last byte incl spare
  localparam int MAX_PARTIAL = 4;
  localparam logic [2:0] PARTIAL_LIMIT = 3'h4;

  // --------------------------------------------------------------
  // timing, ns, at 200 MHz
  // --------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int PULSE_NS = 15;        // strobe low/high phases, >= 12 ns
  localparam int READY_TO_RD_NS = 20;  // ready to first output strobe fall
  localparam int WHR_NS = 60;          // write high to read low
  localparam int WB_NS = 100;          // write high to busy
  localparam int REA_NS = 20;          // output strobe fall to data valid
  localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RR_CYC = (READY_TO_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WHR_CYC = (WHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WB_CYC = (WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // read low phase: access time plus two sync stages plus one cycle margin
  localparam int RD_LOW_CYC = (REA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 3;
  localparam int CNT_W = 8;

  // --------------------------------------------------------------
  // request / pin carriers
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ, OP_PROG, OP_ERASE, OP_STATUS, OP_RESET, OP_IDENT
  } op_t;

  typedef struct packed {
    op_t op;
    logic [COL_W-1:0] col;
    logic [PAGE_W-1:0] page;
    logic [COL_W-1:0] len;  // bytes minus one for read/program
  } req_t;

  typedef struct packed {
    logic cmdLatch;
    logic addrLatch;
    logic chipSel_n;
    logic writeStrobe_n;
    logic outputStrobe_n;
    logic writeGuard_n;
  } pins_t;

endpackage

// File: nand_host.sv
`timescale 1ns/1ps
// Notes on behaviour
// - at most four partial programs per page; only the last programmed page is tracked, another page restarts the count
// - never drive bus while device drives
// - program columns limited to 0..2111
// - wait 20 ns after ready before read
// - command codes and busy acceptance
// - four address cycles, column then page, for read and program; erase sends two page cycles, ident one
module nand_host
  import nand_host_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic reqValid,
  input wire req_t req,
  input wire logic wrValid,
  input wire logic [7:0] wrData,
  input wire logic writeGuardAllow,
  input wire logic [7:0] ioIn,
  input wire logic readyBusyIn,
  output logic reqReady,
  output logic wrReady,
  output logic rdValid,
  output logic [7:0] rdData,
  output logic opDone,
  output logic opRefused,
  output logic [7:0] ioOut,
  output logic ioOe_n,
  output pins_t pins
);

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  logic [7:0] ioMeta, ioSync;  // first stage only feeds second
  logic rbMeta, rbSync;

  always_ff @(posedge ref_clk) begin
    ioMeta <= ioIn;
    ioSync <= ioMeta;
    rbMeta <= readyBusyIn;
    rbSync <= rbMeta;
  end

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  typedef enum {
    S_IDLE, S_CMD1, S_ADDR, S_DATA_W, S_CMD2, S_WAIT_B, S_WAIT_R,
    S_GAP, S_RD, S_DONE
  } state_t;

  state_t state;
  req_t cur;
  logic [2:0] step;          // address cycle index
  logic [CNT_W-1:0] timer;   // phase timer
  logic [COL_W-1:0] count;   // bytes still to move, minus one
  logic phase;               // 0 strobe low, 1 strobe high
  logic [2:0] partials;      // programs issued to current page
  logic [PAGE_W-1:0] lastPage;

  wire timerDone = (timer == '0);
  // guard and partial checks decided at request time
  // guard blocks writes
  wire guardBlock = ((req.op == OP_PROG) || (req.op == OP_ERASE)) && !writeGuardAllow;
  wire partialBlock = (req.op == OP_PROG) && (req.page == lastPage) &&
                      (partials >= PARTIAL_LIMIT);
  // column range cap
  // one extra bit so a large column plus length cannot wrap below the limit
  wire colBlock = (req.op == OP_PROG) &&
                  (({1'b0, req.col} + {1'b0, req.len}) > {1'b0, COL_LAST});
  wire refuse = guardBlock || partialBlock || colBlock;
  wire [7:0] firstCmd = (cur.op == OP_READ) ? CMD_READ_1 :
                        (cur.op == OP_PROG) ? CMD_PROG_1 :
                        (cur.op == OP_ERASE) ? CMD_ERASE_1 :
                        (cur.op == OP_STATUS) ? CMD_STATUS :
                        (cur.op == OP_IDENT) ? CMD_IDENT : CMD_RESET;
  wire [7:0] secondCmd = (cur.op == OP_READ) ? CMD_READ_2 :
                         (cur.op == OP_PROG) ? CMD_PROG_2 : CMD_ERASE_2;
  wire [2:0] addrFirst = (cur.op == OP_ERASE) ? 3'h2 : 3'h0;
  wire [2:0] addrLast = (cur.op == OP_IDENT) ? 3'h0 : 3'h3;
  wire [7:0] addrByte = (step == 3'h0) ? cur.col[7:0] :
                        (step == 3'h1) ? {4'h0, cur.col[11:8]} :
                        (step == 3'h2) ? cur.page[7:0] :
                        {1'b0, cur.page[14:8]};
  wire hasAddr = (cur.op != OP_STATUS) && (cur.op != OP_RESET);
  wire hasRead = (cur.op == OP_READ) || (cur.op == OP_STATUS) || (cur.op == OP_IDENT);
  wire [CNT_W-1:0] pulseCyc = CNT_W'(PULSE_CYC - 1);
  wire [CNT_W-1:0] rdLowCyc = CNT_W'(RD_LOW_CYC - 1);

  // state register and strobes; write and output strobes change only at phase boundaries
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state <= S_IDLE;
      cur <= '0;
      step <= 3'h0;
      timer <= '0;
      count <= '0;
      phase <= 1'b0;
      partials <= 3'h0;
      lastPage <= '0;
      reqReady <= 1'b0;
      wrReady <= 1'b0;
      rdValid <= 1'b0;
      rdData <= 8'h00;
      opDone <= 1'b0;
      opRefused <= 1'b0;
      ioOut <= 8'h00;
      ioOe_n <= 1'b1;
      pins <= '{cmdLatch: 1'b0, addrLatch: 1'b0, chipSel_n: 1'b1,
                writeStrobe_n: 1'b1, outputStrobe_n: 1'b1, writeGuard_n: 1'b0};
    end else begin
      rdValid <= 1'b0;
      opDone <= 1'b0;
      opRefused <= 1'b0;
      wrReady <= 1'b0;
      pins.writeGuard_n <= writeGuardAllow;
      // latches drop one cycle after the closing write rise, keeping hold time
      if (state != S_CMD1 && state != S_CMD2) pins.cmdLatch <= 1'b0;
      if (state != S_ADDR) pins.addrLatch <= 1'b0;
      if (!timerDone) timer <= timer - 1'b1;
      case (state)
        // idle: accept a request, bus released
        S_IDLE: begin
          reqReady <= 1'b1;
          pins.chipSel_n <= 1'b1;
          ioOe_n <= 1'b1;
          if (reqValid && reqReady) begin
            reqReady <= 1'b0;
            if (refuse) begin
              opRefused <= 1'b1;
            end else begin
              cur <= req;
              count <= req.len;
              if (req.op == OP_PROG) begin
                partials <= (req.page == lastPage) ? partials + 3'h1 : 3'h1;
                lastPage <= req.page;
              end else if (req.op == OP_ERASE && req.page[14:6] == lastPage[14:6]) begin
                partials <= 3'h0;
              end
              pins.chipSel_n <= 1'b0;
              phase <= 1'b0;
              timer <= pulseCyc;
              state <= S_CMD1;
            end
          end
        end
        // command cycle: cmdLatch high, write strobe low then rise
        // command latched on rise
        S_CMD1, S_CMD2: if (timerDone) begin
          ioOut <= (state == S_CMD1) ? firstCmd : secondCmd;
          ioOe_n <= 1'b0;
          pins.cmdLatch <= 1'b1;
          pins.writeStrobe_n <= phase;
          phase <= ~phase;
          timer <= pulseCyc;
          if (phase) begin
            step <= addrFirst;
            if (state == S_CMD2) state <= S_WAIT_B;
            else if (cur.op == OP_RESET) state <= S_WAIT_B;
            else if (hasAddr) state <= S_ADDR;
            else state <= S_GAP;
          end
        end
        // address cycles, write strobe toggles per byte
        // address latched on rise
        S_ADDR: if (timerDone) begin
          ioOut <= addrByte;
          ioOe_n <= 1'b0;
          pins.addrLatch <= 1'b1;
          pins.writeStrobe_n <= phase;
          phase <= ~phase;
          timer <= pulseCyc;
          if (phase) begin
            step <= step + 3'h1;
            if (step == addrLast) begin
              if (cur.op == OP_PROG) state <= S_DATA_W;
              else if (cur.op == OP_IDENT) state <= S_GAP;
              else state <= S_CMD2;
            end
          end
        end
        // program data: one byte per write strobe, paced by wrValid
        S_DATA_W: if (timerDone) begin
          if (!phase) begin
            wrReady <= 1'b1;
            if (wrValid && wrReady) begin
              wrReady <= 1'b0;
              ioOut <= wrData;
              ioOe_n <= 1'b0;
              pins.writeStrobe_n <= 1'b0;
              phase <= 1'b1;
              timer <= pulseCyc;
            end
          end else begin
            pins.writeStrobe_n <= 1'b1;
            phase <= 1'b0;
            timer <= pulseCyc;
            count <= count - 1'b1;
            if (count == '0) state <= S_CMD2;
          end
        end
        // fixed WB_CYC wait after final command, busy not sampled here
        // busy low through array op
        S_WAIT_B: begin
          ioOe_n <= 1'b1;
          // phase marks the long wait as started; cleared on the way out
          if (timerDone && !phase) begin
            phase <= 1'b1;
            timer <= CNT_W'(WB_CYC);
          end else if (timerDone) begin
            phase <= 1'b0;
            state <= S_WAIT_R;
          end
        end
        // page load bounded reset recovery bounded
        S_WAIT_R: if (rbSync) begin
          timer <= CNT_W'(RR_CYC);
          state <= (cur.op == OP_READ) ? S_GAP : S_DONE;
        end
        // spacing before first output strobe fall
        S_GAP: begin
          ioOe_n <= 1'b1;
          if (timerDone && !phase) begin
            phase <= 1'b1;
            timer <= CNT_W'(WHR_CYC);
          end else if (timerDone) begin
            phase <= 1'b0;
            state <= hasRead ? S_RD : S_DONE;
          end
        end
        // read bytes; long low phase covers access time and sync stages
        // host bus released while reading
        S_RD: if (timerDone) begin
          ioOe_n <= 1'b1;
          pins.outputStrobe_n <= phase;
          // long low phase, byte taken before the rise
          timer <= phase ? pulseCyc : rdLowCyc;
          phase <= ~phase;
          if (phase) begin
            rdData <= ioSync;
            rdValid <= 1'b1;
            count <= count - 1'b1;
            if (count == '0 || cur.op == OP_STATUS) state <= S_DONE;
          end
        end
        // chip select rise ends output drive
        S_DONE: begin
          pins.chipSel_n <= 1'b1;
          opDone <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule

// File: nand_host_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// pin sequencing checks, host side
// ----------------------------------------
module nand_host_monitor
  import nand_host_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic writeGuardAllow,
  input wire logic readyBusyIn,
  input wire logic ioOe_n,
  input wire logic opRefused,
  input wire pins_t pins
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // reset must park chip select, write and output strobes and the bus driver
  reset_idle_a: assert property (disable iff (1'b0) !rst_b |=> pins.chipSel_n &&
    pins.writeStrobe_n && pins.outputStrobe_n && ioOe_n) else $error("pins busy in reset");
  latch_excl_a: assert property (!(pins.cmdLatch && pins.addrLatch))
    else $error("both latch strobes high");
  write_pulse_a: assert property ($fell(pins.writeStrobe_n) |=> !pins.writeStrobe_n [*2])
    else $error("write strobe low too short");
  read_pulse_a: assert property ($fell(pins.outputStrobe_n) |=> !pins.outputStrobe_n [*2])
    else $error("output strobe low too short");
  bus_clash_a: assert property (!pins.outputStrobe_n |-> ioOe_n)
    else $error("host drives bus during output");
  strobe_excl_a: assert property (!(!pins.writeStrobe_n && !pins.outputStrobe_n))
    else $error("both strobes low");
  ready_gap_a: assert property ($rose(readyBusyIn) |-> pins.outputStrobe_n [*4])
    else $error("output strobe too soon after ready");
  guard_pin_a: assert property (!writeGuardAllow [*3] |-> !pins.writeGuard_n)
    else $error("guard pin not low");
  refuse_pulse_a: assert property (opRefused |=> !opRefused)
    else $error("refusal longer than one cycle");
  select_a: assert property (!pins.writeStrobe_n |-> !pins.chipSel_n)
    else $error("write strobe without select");
endmodule
bind nand_host nand_host_monitor mon (.ref_clk(ref_clk), .rst_b(rst_b),
  .writeGuardAllow(writeGuardAllow), .readyBusyIn(readyBusyIn), .ioOe_n(ioOe_n),
  .opRefused(opRefused), .pins(pins));

// File: nand_dev_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// behavioural flash device on the pins
// ----------------------------------------
module nand_dev_model
  import nand_host_pkg::*;
#(
  parameter int BUSY_CYC = 40,
  parameter logic [7:0] STAT_BYTE = 8'hc0,
  parameter logic [7:0] IDENT_CODE = 8'h5a  // arbitrary value
)
(
  input wire logic ref_clk,
  input wire pins_t pins,
  input wire logic [7:0] bus,
  input wire logic hostOe_n,
  output logic [7:0] devData,
  output logic devOe,
  output logic readyBusy
);
  logic wsPrev = 1'b1, osPrev = 1'b1, partialErr = 1'b0, clash = 1'b0, colErr = 1'b0;
  logic [7:0] lastCmd = 8'h00, mode = 8'h00;
  logic [31:0] addrSr = 32'h0;
  logic [11:0] colPtr = 12'h0;
  int busyCnt = 0, partial = 0, dataCnt = 0;
  initial devOe = 1'b0;
  initial devData = 8'h00;
  // busy low while an array operation runs, short stand-ins
  assign readyBusy = (busyCnt == 0);
  always @(posedge ref_clk) begin
    wsPrev <= pins.writeStrobe_n;
    osPrev <= pins.outputStrobe_n;
    if (busyCnt > 0) busyCnt <= busyCnt - 1;
    // flag contention on the shared bus
    if (devOe && !hostOe_n) clash <= 1'b1;
    if (!wsPrev && pins.writeStrobe_n && !pins.chipSel_n) begin
      if (pins.cmdLatch) begin
        lastCmd <= bus;
        if (!(bus inside {CMD_READ_2, CMD_PROG_2, CMD_ERASE_2})) addrSr <= 32'h0;
        if (bus != CMD_READ_2) mode <= bus;
        if (bus inside {CMD_READ_2, CMD_PROG_2, CMD_ERASE_2, CMD_RESET}) busyCnt <= BUSY_CYC;
        if (bus == CMD_READ_2) colPtr <= {addrSr[19:16], addrSr[31:24]};
        // partial program budget, cleared by erase
        if (bus == CMD_PROG_2) partial <= partial + 1;
        if (bus == CMD_PROG_2 && partial >= MAX_PARTIAL) partialErr <= 1'b1;
        if (bus == CMD_ERASE_2) partial <= 0;
        if (bus == CMD_PROG_1) dataCnt <= 0;
      end
      // program data must stay inside the page incl spare
      if (!pins.cmdLatch && !pins.addrLatch && mode == CMD_PROG_1) begin
        if (int'({addrSr[19:16], addrSr[31:24]}) + dataCnt > int'(COL_LAST))
          colErr <= 1'b1;
        dataCnt <= dataCnt + 1;
      end
      if (pins.addrLatch) addrSr <= {addrSr[23:0], bus};
    end
    // byte out on strobe fall, drivers off on rise
    if (osPrev && !pins.outputStrobe_n) begin
      devOe <= 1'b1;
      devData <= (mode == CMD_STATUS) ? STAT_BYTE : (mode == CMD_IDENT) ? IDENT_CODE : colPtr[7:0];
      colPtr <= colPtr + 12'h1;
    end else if (!osPrev && pins.outputStrobe_n) begin
      devOe <= 1'b0;
      devData <= ~devData;  // released bus must not look valid
    end
  end
endmodule

// File: test_nand_host.sv
`timescale 1ns/1ps
module test_nand_host
  import nand_host_pkg::*;
;
  typedef struct packed {
    op_t op; logic [11:0] col; logic [14:0] page; logic [11:0] len;
    logic guard; logic refused; logic [7:0] cmd; logic [7:0] d0;
  } row_t;
  logic ref_clk = 1'b0, rst_b = 1'b0, reqValid = 1'b0, wrValid = 1'b1, guard = 1'b1;
  logic [7:0] wrData = 8'h00, devData, ioOut, rdData;
  logic reqReady, wrReady, rdValid, opDone, opRefused, ioOe_n, devOe, readyBusy;
  req_t req = '0;
  pins_t pins;
  int err_total = 0, comparisons = 0, nb;
  wire logic [7:0] ioIn = ioOe_n ? devData : ioOut;
  row_t rows [14] = '{
    '{OP_READ, 12'h005, 15'h0003, 12'h2, 1'b1, 1'b0, 8'h30, 8'h05},
    '{OP_PROG, 12'h000, 15'h0009, 12'h1, 1'b1, 1'b0, 8'h10, 8'h00},
    '{OP_PROG, 12'h010, 15'h0009, 12'h1, 1'b1, 1'b0, 8'h10, 8'h00},
    '{OP_PROG, 12'h020, 15'h0009, 12'h0, 1'b1, 1'b0, 8'h10, 8'h00},
    '{OP_PROG, 12'h83f, 15'h0009, 12'h0, 1'b1, 1'b0, 8'h10, 8'h00},
    '{OP_PROG, 12'h030, 15'h0009, 12'h0, 1'b1, 1'b1, 8'h10, 8'h00},
    '{OP_ERASE, 12'h000, 15'h0009, 12'h0, 1'b1, 1'b0, 8'hd0, 8'h00},
    '{OP_PROG, 12'h83f, 15'h0009, 12'h1, 1'b1, 1'b1, 8'hd0, 8'h00},
    '{OP_PROG, 12'h000, 15'h0009, 12'h0, 1'b0, 1'b1, 8'hd0, 8'h00},
    '{OP_ERASE, 12'h000, 15'h0009, 12'h0, 1'b0, 1'b1, 8'hd0, 8'h00},
    '{OP_STATUS, 12'h000, 15'h0000, 12'h0, 1'b1, 1'b0, 8'h70, 8'hc0},
    '{OP_IDENT, 12'h000, 15'h0000, 12'h0, 1'b1, 1'b0, 8'h90, 8'h5a},
    '{OP_RESET, 12'h000, 15'h0000, 12'h0, 1'b1, 1'b0, 8'hff, 8'h00},
    '{OP_READ, 12'h83e, 15'h7fff, 12'h1, 1'b1, 1'b0, 8'h30, 8'h3e}};
  always #2.5 ref_clk = ~ref_clk;
  // next program byte once the host takes a slot
  always @(posedge ref_clk) if (wrReady) wrData <= wrData + 8'h1;
  nand_host dut (.ref_clk(ref_clk), .rst_b(rst_b), .reqValid(reqValid), .req(req),
    .wrValid(wrValid), .wrData(wrData), .writeGuardAllow(guard), .ioIn(ioIn),
    .readyBusyIn(readyBusy), .reqReady(reqReady), .wrReady(wrReady), .rdValid(rdValid),
    .rdData(rdData), .opDone(opDone), .opRefused(opRefused), .ioOut(ioOut),
    .ioOe_n(ioOe_n), .pins(pins));
  nand_dev_model dev (.ref_clk(ref_clk), .pins(pins), .bus(ioIn), .hostOe_n(ioOe_n),
    .devData(devData), .devOe(devOe), .readyBusy(readyBusy));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // one request, bytes collected until done
  // ----------------------------------------
  task automatic run(input row_t r);
    logic [31:0] ea;
    int n;
    n = 0;
    ea = (r.op inside {OP_READ, OP_PROG}) ? {r.col[7:0], 4'h0, r.col[11:8], r.page[7:0],
      1'b0, r.page[14:8]} : (r.op == OP_ERASE) ? {16'h0, r.page[7:0], 1'b0, r.page[14:8]} : 0;
    @(posedge ref_clk);
    guard <= r.guard;
    req <= '{op: r.op, col: r.col, page: r.page, len: r.len};
    reqValid <= 1'b1;
    do @(posedge ref_clk); while (!reqReady);
    reqValid <= 1'b0;
    repeat (3000) begin
      @(posedge ref_clk);
      if (rdValid === 1'b1) begin
        check(rdData, r.d0 + n[7:0]);
        n++;
      end
      if (opDone === 1'b1 || opRefused === 1'b1) break;
    end
    check(opRefused, r.refused);
    check(dev.lastCmd, r.cmd);
    if (!r.refused) check(dev.addrSr, ea);
    nb = (r.op inside {OP_READ, OP_STATUS, OP_IDENT} && !r.refused) ? r.len + 1 : 0;
    check(n, nb);
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    err_total++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (rows[i]) run(rows[i]);
    // reset in mid-read must park the pins
    fork run(rows[0]); join_none
    repeat (50) @(posedge ref_clk);
    disable fork;
    reqValid <= 1'b0;
    rst_b <= 1'b0;
    repeat (10) @(posedge ref_clk);
    check({pins.chipSel_n, pins.writeStrobe_n, pins.outputStrobe_n, ioOe_n}, 4'hf);
    rst_b <= 1'b1;
    run(rows[10]);
    check({dev.partialErr, dev.clash}, 2'b00);
    check(dev.colErr, 1'b0);
    stop_test();
  end
endmodule
